// ===== hw/rswc_top.sv
// Purpose: Reset cause sorting, sleep and wake sequencing, with an Avalon-MM register file
// Assumes: i_reset_n is the power-on reset; core inputs are synchronous to i_clk
// Notes:   Contract
// Contract
// - Six reset causes are told apart and recorded.
// - Retained register keeps its value across every reset except power-on.
// - Core registers are reset on power-on, master clear, watchdog reset, brown-out.
// - Watchdog wake from sleep resets nothing and resumes execution.
// - Timeout and powerdown status bits follow the event that occurred.
// - Master clear input is filtered; driver holds it low long enough.
// - Master clear pin is never driven by internal reset sources.
// - Crystal, high-speed, low-power modes wait 1024 oscillator periods on wake.
// - Resistor-capacitor mode skips the start-up wait on wake.
// - Interrupt wake with enable runs next instruction, dummies, then 0004h.
// - Instruction rate clock output undriven outside resistor-capacitor mode.
// - Brown-out reset while enabled and supply below trip voltage.
// - Leaving reset, fetch starts at program address 0000h.
`timescale 1ns/10ps

module rswc_top #(
  parameter int OST_CYCLES    = rswc_pkg::OST_CYCLES,
  parameter int FILTER_CYCLES = rswc_pkg::MASTER_CLEAR_N_FILTER_CYCLES
) (
  // Clock and power-on reset
  input  wire logic                 i_clk,
  input  wire logic                 i_reset_n,
  // Avalon-MM slave
  input  wire logic [4:0]           i_avs_address,
  input  wire logic                 i_avs_read,
  input  wire logic                 i_avs_write,
  input  wire logic [31:0]          i_avs_writedata,
  input  wire logic [3:0]           i_avs_byteenable,
  output logic      [31:0]          o_avs_readdata,
  output logic                      o_avs_waitrequest,
  // Pins and supply monitor
  input  wire logic                 i_master_clear_n,
  output logic                      o_master_clear_out,
  output logic                      o_master_clear_oe,
  input  wire logic                 i_brownout_low,
  output logic                      o_instr_rate_clock_out,
  output logic                      o_instr_rate_clock_oe,
  // Core handshake
  input  wire logic                 i_sleep_cmd,
  input  wire logic                 i_watchdog_timer_expired,
  input  wire logic                 i_irq_pending,
  input  wire logic                 i_global_irq_enable,
  output logic                      o_core_reset_n,
  output logic                      o_core_run,
  output logic                      o_dummy_cycle,
  output logic                      o_pc_load,
  output logic      [12:0]          o_pc_vector,
  output rswc_pkg::rswc_status_t    o_status,
  output logic                      o_irq
);

  localparam int HW = $clog2(rswc_pkg::RESET_HOLD_CYCLES + 1);
  localparam int OW = (OST_CYCLES > 1) ? $clog2(OST_CYCLES) : 1;

  // ************************************************************
  // Pin conditioning
  // ************************************************************
  logic [1:0] pins_sync;
  logic       master_clear_n_filt;

  rswc_sync2 #(
    .WIDTH     (2),
    .RESET_VAL (2'h1)
  ) u_sync (
    .i_clk     (i_clk),
    .i_reset_n (i_reset_n),
    .i_async   ({i_brownout_low, i_master_clear_n}),
    .o_sync    (pins_sync)
  );

  rswc_glitch_filter #(
    .CYCLES    (FILTER_CYCLES),
    .INIT_VAL  (1'b1)
  ) u_filter (
    .i_clk     (i_clk),
    .i_reset_n (i_reset_n),
    .i_level   (pins_sync[0]),
    .o_level   (master_clear_n_filt)
  );

  // ************************************************************
  // Registers and state
  // ************************************************************
  rswc_pkg::rswc_state_t  state_reg;
  rswc_pkg::rswc_state_t  state_next;
  rswc_pkg::rswc_status_t status_reg;
  rswc_pkg::rswc_osc_mode_t osc_mode;
  logic [rswc_pkg::CTRL_WIDTH-1:0]   ctrl_reg;
  logic [rswc_pkg::NUM_CAUSES-1:0]   irq_status_reg;
  logic [rswc_pkg::NUM_CAUSES-1:0]   irq_mask_reg;
  logic [rswc_pkg::NUM_CAUSES-1:0]   cause_event;
  logic [rswc_pkg::RETAIN_WIDTH-1:0] retain_reg;
  logic [HW-1:0]                     hold_cnt_reg;
  logic [OW-1:0]                     ost_cnt_reg;
  logic [rswc_pkg::INSTR_DIV_BITS-1:0] div_reg;
  logic [31:0]                       rdata_next;
  logic                              wake_vector_reg;
  logic                              master_clear_n_low;
  logic                              bor_low;
  logic                              wdt_reset;
  logic                              wdt_wake;
  logic                              irq_wake;
  logic                              reset_req;
  logic                              enter_reset;
  logic                              bus_req;
  logic                              bus_wr;
  rswc_pkg::rswc_cause_t             new_cause;

  assign osc_mode = rswc_pkg::rswc_osc_mode_t'(ctrl_reg[rswc_pkg::CTRL_OSC_MSB:
                                                        rswc_pkg::CTRL_OSC_LSB]);

  // ************************************************************
  // Cause detection
  // ************************************************************
  always_comb
  begin
    master_clear_n_low  = ~master_clear_n_filt;
    bor_low   = ctrl_reg[rswc_pkg::CTRL_BOREN_BIT] & pins_sync[1];
    wdt_reset = i_watchdog_timer_expired && (state_reg != rswc_pkg::ST_SLEEP)
                && (state_reg != rswc_pkg::ST_RESET);
    wdt_wake  = i_watchdog_timer_expired && (state_reg == rswc_pkg::ST_SLEEP);
    irq_wake  = i_irq_pending && (state_reg == rswc_pkg::ST_SLEEP);
    reset_req = master_clear_n_low | bor_low | wdt_reset;
    enter_reset = reset_req && (state_reg != rswc_pkg::ST_RESET);
    if (bor_low)
      new_cause = rswc_pkg::CAUSE_BROWN_OUT;
    else if (master_clear_n_low && (state_reg == rswc_pkg::ST_SLEEP))
      new_cause = rswc_pkg::CAUSE_MASTER_CLEAR_SLEEP;
    else if (master_clear_n_low)
      new_cause = rswc_pkg::CAUSE_MASTER_CLEAR_RUN;
    else
      new_cause = rswc_pkg::CAUSE_WATCHDOG_RESET;
    cause_event = '0;
    if (enter_reset)
      cause_event[new_cause] = 1'b1;
    if (wdt_wake && !reset_req)
      cause_event[rswc_pkg::CAUSE_WATCHDOG_WAKE] = 1'b1;
  end

  // ************************************************************
  // Sequencer
  // ************************************************************
  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      rswc_pkg::ST_RESET:
        if (!master_clear_n_low && !bor_low
            && hold_cnt_reg == HW'(rswc_pkg::RESET_HOLD_CYCLES))
          state_next = rswc_pkg::ST_RUN;
      rswc_pkg::ST_RUN:
        if (i_sleep_cmd)
          state_next = rswc_pkg::ST_SLEEP;
      rswc_pkg::ST_SLEEP:
        if (wdt_wake || irq_wake)
        begin
          if (osc_mode == rswc_pkg::RESISTOR_CAPACITOR_OSC_MODE)
            state_next = rswc_pkg::ST_WAKE;
          else
            state_next = rswc_pkg::ST_OST;
        end
      rswc_pkg::ST_OST:
        if (ost_cnt_reg == OW'(OST_CYCLES - 1))
          state_next = rswc_pkg::ST_WAKE;
      rswc_pkg::ST_WAKE:
        if (wake_vector_reg)
          state_next = rswc_pkg::ST_DUMMY1;
        else
          state_next = rswc_pkg::ST_RUN;
      rswc_pkg::ST_DUMMY1:
        state_next = rswc_pkg::ST_DUMMY2;
      rswc_pkg::ST_DUMMY2:
        state_next = rswc_pkg::ST_VECTOR;
      rswc_pkg::ST_VECTOR:
        state_next = rswc_pkg::ST_RUN;
      default:
        state_next = rswc_pkg::ST_RESET;
    endcase
    if (enter_reset)
      state_next = rswc_pkg::ST_RESET;
  end

  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      state_reg <= rswc_pkg::ST_RESET;
    else
      state_reg <= state_next;
  end

  // Hold restarts while master clear or brown-out is still active
  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      hold_cnt_reg <= '0;
    else if (state_reg != rswc_pkg::ST_RESET || reset_req)
      hold_cnt_reg <= '0;
    else if (hold_cnt_reg != HW'(rswc_pkg::RESET_HOLD_CYCLES))
      hold_cnt_reg <= hold_cnt_reg + HW'(1);
  end

  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      ost_cnt_reg <= '0;
    else if (state_reg == rswc_pkg::ST_OST)
      ost_cnt_reg <= ost_cnt_reg + OW'(1);
    else
      ost_cnt_reg <= '0;
  end

  // Watchdog wake resumes in line even with interrupts enabled
  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      wake_vector_reg <= 1'b0;
    else if (state_reg == rswc_pkg::ST_SLEEP)
      wake_vector_reg <= irq_wake && !wdt_wake && i_global_irq_enable;
  end

  // ************************************************************
  // Status bits
  // ************************************************************
  // status per event
  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      status_reg <= rswc_pkg::STATUS_RESET;
    end
    else
    begin
      status_reg.sleeping <= (state_next == rswc_pkg::ST_SLEEP)
                             || (state_next == rswc_pkg::ST_OST);
      if (enter_reset)
      begin
        status_reg.cause <= new_cause;
        case (new_cause)
          rswc_pkg::CAUSE_MASTER_CLEAR_SLEEP:
          begin
            status_reg.timeout_status_n   <= 1'b1;
            status_reg.powerdown_status_n <= 1'b0;
          end
          rswc_pkg::CAUSE_WATCHDOG_RESET:
          begin
            status_reg.timeout_status_n   <= 1'b0;
            status_reg.powerdown_status_n <= 1'b1;
          end
          rswc_pkg::CAUSE_BROWN_OUT:
          begin
            status_reg.timeout_status_n   <= 1'b1;
            status_reg.powerdown_status_n <= 1'b1;
          end
          default:
            status_reg.timeout_status_n <= status_reg.timeout_status_n;
        endcase
      end
      else if (wdt_wake)
      begin
        status_reg.cause              <= rswc_pkg::CAUSE_WATCHDOG_WAKE;
        status_reg.timeout_status_n   <= 1'b0;
        status_reg.powerdown_status_n <= 1'b0;
      end
      else if (state_reg == rswc_pkg::ST_RUN && i_sleep_cmd)
      begin
        status_reg.timeout_status_n   <= 1'b1;
        status_reg.powerdown_status_n <= 1'b0;
      end
    end
  end

  // ************************************************************
  // Core controls
  // ************************************************************
  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      o_core_reset_n <= 1'b0;
      o_core_run     <= 1'b0;
      o_dummy_cycle  <= 1'b0;
      o_pc_load      <= 1'b0;
      o_pc_vector    <= rswc_pkg::RESET_VECTOR;
    end
    else
    begin
      o_core_reset_n <= (state_next != rswc_pkg::ST_RESET);
      o_core_run     <= (state_next == rswc_pkg::ST_RUN) || (state_next == rswc_pkg::ST_WAKE);
      o_dummy_cycle  <= (state_next == rswc_pkg::ST_DUMMY1)
                        || (state_next == rswc_pkg::ST_DUMMY2);
      o_pc_load      <= 1'b0;
      if (state_reg == rswc_pkg::ST_RESET && state_next == rswc_pkg::ST_RUN)
      begin
        o_pc_load   <= 1'b1;
        o_pc_vector <= rswc_pkg::RESET_VECTOR;
      end
      else if (state_next == rswc_pkg::ST_VECTOR)
      begin
        o_pc_load   <= 1'b1;
        o_pc_vector <= rswc_pkg::IRQ_VECTOR;
      end
    end
  end

  // ************************************************************
  // Pins
  // ************************************************************
  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      o_master_clear_out     <= 1'b0;
      o_master_clear_oe      <= 1'b0;
      div_reg                <= '0;
      o_instr_rate_clock_out <= 1'b0;
      o_instr_rate_clock_oe  <= 1'b0;
    end
    else
    begin
      o_master_clear_out     <= 1'b0;
      o_master_clear_oe      <= 1'b0;
      div_reg                <= div_reg + rswc_pkg::INSTR_DIV_BITS'(1);
      o_instr_rate_clock_out <= div_reg[rswc_pkg::INSTR_DIV_BITS-1];
      o_instr_rate_clock_oe  <= (osc_mode == rswc_pkg::RESISTOR_CAPACITOR_OSC_MODE);
    end
  end

  // ************************************************************
  // Avalon-MM slave
  // ************************************************************
  // One wait cycle per access; write lands on the acked edge, read data one edge before it
  assign bus_req = i_avs_read | i_avs_write;
  assign bus_wr  = i_avs_write && !o_avs_waitrequest && i_avs_byteenable[0];

  always_comb
  begin
    rdata_next = 32'h0000_0000;
    case (i_avs_address)
      rswc_pkg::ADDR_CTRL:       rdata_next[rswc_pkg::CTRL_WIDTH-1:0] = ctrl_reg;
      rswc_pkg::ADDR_STATUS:     rdata_next[$bits(status_reg)-1:0]    = status_reg;
      rswc_pkg::ADDR_IRQ_STATUS: rdata_next[rswc_pkg::NUM_CAUSES-1:0] = irq_status_reg;
      rswc_pkg::ADDR_IRQ_MASK:   rdata_next[rswc_pkg::NUM_CAUSES-1:0] = irq_mask_reg;
      rswc_pkg::ADDR_RETAIN:     rdata_next[rswc_pkg::RETAIN_WIDTH-1:0] = retain_reg;
      default:                   rdata_next = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      o_avs_waitrequest <= 1'b1;
      o_avs_readdata    <= 32'h0000_0000;
    end
    else
    begin
      o_avs_waitrequest <= !(bus_req && o_avs_waitrequest);
      if (i_avs_read && o_avs_waitrequest)
        o_avs_readdata <= rdata_next;
    end
  end

  // Configuration and mask survive all but power-on
  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      ctrl_reg     <= rswc_pkg::CTRL_RESET;
      irq_mask_reg <= rswc_pkg::IRQ_MASK_RESET;
    end
    else if (bus_wr && i_avs_address == rswc_pkg::ADDR_CTRL)
      ctrl_reg <= i_avs_writedata[rswc_pkg::CTRL_WIDTH-1:0];
    else if (bus_wr && i_avs_address == rswc_pkg::ADDR_IRQ_MASK)
      irq_mask_reg <= i_avs_writedata[rswc_pkg::NUM_CAUSES-1:0];
  end

  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      retain_reg <= rswc_pkg::RETAIN_RESET;
    else if (bus_wr && i_avs_address == rswc_pkg::ADDR_RETAIN)
      retain_reg <= i_avs_writedata[rswc_pkg::RETAIN_WIDTH-1:0];
  end

  // ************************************************************
  // Interrupt
  // ************************************************************
  // Set beats write-one-to-clear in the same cycle
  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      irq_status_reg <= rswc_pkg::IRQ_STATUS_RESET;
    else if (bus_wr && i_avs_address == rswc_pkg::ADDR_IRQ_STATUS)
      irq_status_reg <= (irq_status_reg & ~i_avs_writedata[rswc_pkg::NUM_CAUSES-1:0])
                        | cause_event;
    else
      irq_status_reg <= irq_status_reg | cause_event;
  end

  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      o_irq    <= 1'b0;
      o_status <= rswc_pkg::STATUS_RESET;
    end
    else
    begin
      o_irq    <= |(irq_status_reg & irq_mask_reg);
      o_status <= status_reg;
    end
  end

endmodule

// ===== hw/rswc_pkg.sv
// Purpose: Shared constants, register map and types of the reset and wake controller
// Assumes: 250 MHz core clock; one oscillator period equals one core clock period
// Notes:   Offsets are byte addresses on a 32-bit Avalon-MM slave

package rswc_pkg;

  // ************************************************************
  // Timing
  // ************************************************************
  localparam int CLK_PERIOD_NS      = 4;
  localparam int OSC_PERIOD_NS      = 4;
  localparam int OST_OSC_PERIODS    = 1024;
  localparam int OST_CYCLES         = (OST_OSC_PERIODS * OSC_PERIOD_NS + CLK_PERIOD_NS - 1)
                                      / CLK_PERIOD_NS;
  localparam int MASTER_CLEAR_N_MIN_PULSE_NS  = 100;
  localparam int MASTER_CLEAR_N_FILTER_CYCLES = (MASTER_CLEAR_N_MIN_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RESET_HOLD_CYCLES  = 4;
  localparam int INSTR_DIV_BITS     = 2;

  // ************************************************************
  // Program vectors
  // ************************************************************
  localparam logic [12:0] RESET_VECTOR = 13'h0000;
  localparam logic [12:0] IRQ_VECTOR   = 13'h0004;

  // ************************************************************
  // Register map
  // ************************************************************
  localparam logic [4:0] ADDR_CTRL       = 5'h00;
  localparam logic [4:0] ADDR_STATUS     = 5'h04;
  localparam logic [4:0] ADDR_IRQ_STATUS = 5'h08;
  localparam logic [4:0] ADDR_IRQ_MASK   = 5'h0c;
  localparam logic [4:0] ADDR_RETAIN     = 5'h10;

  localparam int CTRL_OSC_LSB   = 0;
  localparam int CTRL_OSC_MSB   = 1;
  localparam int CTRL_BOREN_BIT = 2;
  localparam int CTRL_WIDTH     = 3;
  localparam int NUM_CAUSES     = 6;
  localparam int RETAIN_WIDTH   = 8;

  localparam logic [2:0] CTRL_RESET       = 3'h5;
  localparam logic [5:0] IRQ_STATUS_RESET = 6'h01;
  localparam logic [5:0] IRQ_MASK_RESET   = 6'h00;
  localparam logic [7:0] RETAIN_RESET     = 8'h00;

  // ************************************************************
  // Types
  // ************************************************************
  typedef enum logic [1:0] {
    LOW_POWER_OSC_MODE          = 2'h0,
    CRYSTAL_OSC_MODE            = 2'h1,
    HIGH_SPEED_OSC_MODE         = 2'h2,
    RESISTOR_CAPACITOR_OSC_MODE = 2'h3
  } rswc_osc_mode_t;

  typedef enum logic [2:0] {
    CAUSE_POWER_ON           = 3'h0,
    CAUSE_MASTER_CLEAR_RUN   = 3'h1,
    CAUSE_MASTER_CLEAR_SLEEP = 3'h2,
    CAUSE_WATCHDOG_RESET     = 3'h3,
    CAUSE_WATCHDOG_WAKE      = 3'h4,
    CAUSE_BROWN_OUT          = 3'h5
  } rswc_cause_t;

  // Gray code along reset, run, sleep and the wake path
  typedef enum logic [2:0] {
    ST_RESET  = 3'h0,
    ST_RUN    = 3'h1,
    ST_SLEEP  = 3'h3,
    ST_OST    = 3'h2,
    ST_WAKE   = 3'h6,
    ST_DUMMY1 = 3'h7,
    ST_DUMMY2 = 3'h5,
    ST_VECTOR = 3'h4
  } rswc_state_t;

  // Same layout as the status register, top bit first, down to bit 0
  typedef struct packed {
    logic        sleeping;
    rswc_cause_t cause;
    logic        powerdown_status_n;
    logic        timeout_status_n;
  } rswc_status_t;

  localparam rswc_status_t STATUS_RESET = '{sleeping: 1'b0, cause: CAUSE_POWER_ON,
                                            powerdown_status_n: 1'b1,
                                            timeout_status_n: 1'b1};

endpackage

// ===== hw/rswc_sync2.sv
// Purpose: Two flip-flop synchroniser for pin levels
// Assumes: Input is asynchronous to i_clk
// Notes:   Only the second stage may be read by other logic
`timescale 1ns/10ps

module rswc_sync2 #(
  parameter int               WIDTH     = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  // Clock and reset
  input  wire logic             i_clk,
  input  wire logic             i_reset_n,
  // Levels
  input  wire logic [WIDTH-1:0] i_async,
  output logic      [WIDTH-1:0] o_sync
);

  logic [WIDTH-1:0] meta_reg;

  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      meta_reg <= RESET_VAL;
      o_sync   <= RESET_VAL;
    end
    else
    begin
      meta_reg <= i_async;
      o_sync   <= meta_reg;
    end
  end

endmodule

// ===== hw/rswc_glitch_filter.sv
// Purpose: Passes a level change only after it has stood for a set number of cycles
// Assumes: Input already synchronised to i_clk
// Notes:   Pulses shorter than CYCLES never reach the output
`timescale 1ns/10ps

module rswc_glitch_filter #(
  parameter int   CYCLES   = 25,
  parameter logic INIT_VAL = 1'b1
) (
  // Clock and reset
  input  wire logic i_clk,
  input  wire logic i_reset_n,
  // Levels
  input  wire logic i_level,
  output logic      o_level
);

  localparam int CW = (CYCLES > 1) ? $clog2(CYCLES) : 1;

  logic [CW-1:0] cnt_reg;

  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      cnt_reg <= '0;
      o_level <= INIT_VAL;
    end
    else if (i_level == o_level)
    begin
      cnt_reg <= '0;
    end
    else if (cnt_reg == CW'(CYCLES - 1))
    begin
      cnt_reg <= '0;
      o_level <= i_level;
    end
    else
    begin
      cnt_reg <= cnt_reg + CW'(1);
    end
  end

endmodule

// ===== tb/rswc_props.sv
// Purpose: Port checks for the reset and wake controller
// Assumes: One clock; i_reset_n async, active low
// Notes:   Bound to rswc_top at the foot of this file
`timescale 1ns/10ps

module rswc_props #(
  parameter int FILTER_CYCLES = 25
) (
  input wire logic        i_clk,
  input wire logic        i_reset_n,
  input wire logic        i_avs_read,
  input wire logic        i_avs_write,
  input wire logic        o_avs_waitrequest,
  input wire logic        i_master_clear_n,
  input wire logic        o_master_clear_oe,
  input wire logic        o_core_reset_n,
  input wire logic        o_core_run,
  input wire logic        o_dummy_cycle,
  input wire logic        o_pc_load,
  input wire logic [12:0] o_pc_vector
);
  logic [7:0] low_cnt;

  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);

  // Saturates so a stuck pin cannot wrap
  always_ff @(posedge i_clk or negedge i_reset_n)
    if (!i_reset_n)
      low_cnt <= 8'h00;
    else if (i_master_clear_n)
      low_cnt <= 8'h00;
    else if (low_cnt != 8'hff)
      low_cnt <= low_cnt + 8'h01;

  pin_undriven_a: assert property (!o_master_clear_oe)
    else $error("clear pin driven");
  pin_reset_a: assert property (low_cnt >= FILTER_CYCLES + 6 |-> !o_core_reset_n)
    else $error("held clear pin ignored");
  reset_halt_a: assert property (!o_core_reset_n |-> !o_core_run && !o_pc_load)
    else $error("core runs in reset");
  reset_exit_a: assert property ($rose(o_core_reset_n) |-> o_pc_load && o_pc_vector == 13'h0000)
    else $error("bad reset exit");
  pc_pulse_a: assert property (o_pc_load |=> !o_pc_load)
    else $error("vector load too long");
  dummy_pair_a: assert property ($rose(o_dummy_cycle) |=> o_dummy_cycle ##1
    (!o_dummy_cycle && o_pc_load && o_pc_vector == 13'h0004))
    else $error("bad dummy sequence");
  dummy_halt_a: assert property (o_dummy_cycle |-> !o_core_run)
    else $error("core runs in dummy");
  wait_one_a: assert property ((i_avs_read || i_avs_write) && o_avs_waitrequest |=> !o_avs_waitrequest)
    else $error("bus answer late");
endmodule

bind rswc_top rswc_props #(.FILTER_CYCLES(FILTER_CYCLES)) rswc_props_i (.i_clk, .i_reset_n,
  .i_avs_read, .i_avs_write, .o_avs_waitrequest, .i_master_clear_n, .o_master_clear_oe,
  .o_core_reset_n, .o_core_run, .o_dummy_cycle, .o_pc_load, .o_pc_vector);

// ===== tb/rswc_pin_model.sv
// Purpose: Clear pin driver and supply monitor
// Assumes: Bench calls hold() between other traffic
// Notes:   Pin has a pull-up, so it idles high
`timescale 1ns/10ps

module rswc_pin_model (
  // Clock
  input  wire logic i_clk,
  // Pin and monitor
  output logic      o_master_clear_n,
  output logic      o_brownout_low
);
  initial
  begin
    o_master_clear_n = 1'b1;
    o_brownout_low   = 1'b0;
  end

  task automatic hold(input logic bo, input int n);
    @(posedge i_clk);
    if (bo)
      o_brownout_low <= 1'b1;
    else
      o_master_clear_n <= 1'b0;
    repeat (n) @(posedge i_clk);
    o_brownout_low   <= 1'b0;
    o_master_clear_n <= 1'b1;
  endtask
endmodule

// ===== tb/tb.sv
// Purpose: Self-checking bench for rswc_top
// Assumes: Short start-up wait and filter for run time
// Notes:   Outputs are read at the edge, before it updates them
`timescale 1ns/10ps

module tb;
  localparam int OST = 16;
  logic i_clk, i_reset_n, i_avs_read, i_avs_write, i_sleep_cmd, i_watchdog_timer_expired;
  logic i_irq_pending, i_global_irq_enable, i_master_clear_n, i_brownout_low, z;
  logic o_avs_waitrequest, o_master_clear_out, o_master_clear_oe, o_instr_rate_clock_out;
  logic o_instr_rate_clock_oe, o_core_reset_n, o_core_run, o_dummy_cycle, o_pc_load, o_irq;
  logic [4:0] i_avs_address;
  logic [31:0] i_avs_writedata, o_avs_readdata, q;
  logic [12:0] o_pc_vector;
  rswc_pkg::rswc_status_t o_status;
  int num_errors, n_compared, k;

  rswc_top #(.OST_CYCLES(OST), .FILTER_CYCLES(3)) rswc_top_i (.i_clk, .i_reset_n,
    .i_avs_address, .i_avs_read, .i_avs_write, .i_avs_writedata, .i_avs_byteenable(4'hf),
    .o_avs_readdata, .o_avs_waitrequest, .i_master_clear_n, .o_master_clear_out,
    .o_master_clear_oe, .i_brownout_low, .o_instr_rate_clock_out, .o_instr_rate_clock_oe,
    .i_sleep_cmd, .i_watchdog_timer_expired, .i_irq_pending, .i_global_irq_enable,
    .o_core_reset_n, .o_core_run, .o_dummy_cycle, .o_pc_load, .o_pc_vector, .o_status, .o_irq);
  rswc_pin_model rswc_pin_model_i (.i_clk, .o_master_clear_n(i_master_clear_n),
    .o_brownout_low(i_brownout_low));

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_compared++;
    if (s !== e)
    begin
      num_errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask

  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_avs_read      <= !w;
    i_avs_write     <= w;
    i_avs_address   <= a;
    i_avs_writedata <= d;
    do @(posedge i_clk); while (o_avs_waitrequest);
    q = o_avs_readdata;
    i_avs_read  <= 1'b0;
    i_avs_write <= 1'b0;
  endtask

  task automatic rdc(input logic [4:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(q, e);
  endtask

  // Waits for vector load (0), run (1) or core reset (2); z notes any reset
  task automatic til(input int s, input int lim);
    k = 0;
    z = 1'b0;
    do
    begin
      @(posedge i_clk);
      k++;
      z |= !o_core_reset_n;
    end
    while (k < lim && !(s == 0 ? o_pc_load : s == 1 ? o_core_run : !o_core_reset_n));
  endtask

  task automatic pulse_wdt;
    i_watchdog_timer_expired <= 1'b1;
    @(posedge i_clk);
    i_watchdog_timer_expired <= 1'b0;
  endtask

  task automatic nap;
    i_sleep_cmd <= 1'b1;
    @(posedge i_clk);
    i_sleep_cmd <= 1'b0;
    repeat (3) @(posedge i_clk);
  endtask

  task automatic t_regs;
    rdc(5'h00, 32'h5);
    rdc(5'h08, 32'h1);
    rdc(5'h14, 32'h0);
    bus(1'b1, 5'h10, 32'ha5);
    bus(1'b1, 5'h08, 32'h3f);
    rdc(5'h08, 32'h0);
  endtask

  task automatic t_master_clear_n;
    rswc_pin_model_i.hold(1'b0, 1);
    til(2, 12);
    chk(z, 1'b0);
    rswc_pin_model_i.hold(1'b0, 10);
    chk(o_core_reset_n, 1'b0);
    chk({o_master_clear_oe, o_master_clear_out}, 2'b00);
    til(0, 60);
    chk(o_pc_vector, 13'h0000);
    chk(o_status, {1'b0, rswc_pkg::CAUSE_MASTER_CLEAR_RUN, 2'b11});
    rdc(5'h10, 32'ha5);
    bus(1'b1, 5'h0c, 32'h2);
    repeat (3) @(posedge i_clk);
    chk(o_irq, 1'b1);
    bus(1'b1, 5'h08, 32'h2);
    repeat (3) @(posedge i_clk);
    chk(o_irq, 1'b0);
  endtask

  task automatic t_wake_rc;
    bus(1'b1, 5'h00, 32'h7);
    repeat (2) @(posedge i_clk);
    chk(o_instr_rate_clock_oe, 1'b1);
    q[0] = o_instr_rate_clock_out;
    repeat (2) @(posedge i_clk);
    chk(o_instr_rate_clock_out, !q[0]);
    nap;
    chk(o_status[1:0], 2'b01);
    i_global_irq_enable <= 1'b1;
    i_irq_pending       <= 1'b1;
    til(1, 50);
    chk(k <= 3, 1'b1);
    til(0, 20);
    chk(o_pc_vector, 13'h0004);
    i_global_irq_enable <= 1'b0;
    nap;
    til(0, 8);
    chk(o_pc_load, 1'b0);
    i_irq_pending <= 1'b0;
  endtask

  task automatic t_wake_xt;
    bus(1'b1, 5'h00, 32'h5);
    repeat (2) @(posedge i_clk);
    chk(o_instr_rate_clock_oe, 1'b0);
    nap;
    pulse_wdt;
    til(1, 99);
    chk(k >= OST, 1'b1);
    chk(z, 1'b0);
    chk(o_status[1:0], 2'b00);
    nap;
    rswc_pin_model_i.hold(1'b0, 10);
    til(0, 80);
    chk(o_status, {1'b0, rswc_pkg::CAUSE_MASTER_CLEAR_SLEEP, 2'b01});
  endtask

  task automatic t_resets;
    pulse_wdt;
    til(0, 40);
    chk(z, 1'b1);
    chk(o_status, {1'b0, rswc_pkg::CAUSE_WATCHDOG_RESET, 2'b10});
    rswc_pin_model_i.hold(1'b1, 6);
    til(0, 40);
    chk(o_status, {1'b0, rswc_pkg::CAUSE_BROWN_OUT, 2'b11});
    rdc(5'h08, 32'h3c);
  endtask

  task automatic conclude;
    $display("compared=%0d errors=%0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  initial
  begin
    i_clk = 1'b0;
    forever #2 i_clk = ~i_clk;
  end

  // Whole run needs well under 2000 cycles
  initial
  begin
    #(4 * 6000);
    num_errors++;
    conclude;
  end

  initial
  begin
    {i_reset_n, i_avs_read, i_avs_write, i_sleep_cmd, i_watchdog_timer_expired} = 5'h00;
    {i_irq_pending, i_global_irq_enable} = 2'h0;
    i_avs_address   = 5'h00;
    i_avs_writedata = 32'h0;
    repeat (3) @(posedge i_clk);
    i_reset_n <= 1'b1;
    t_regs;
    t_master_clear_n;
    t_wake_rc;
    t_wake_xt;
    t_resets;
    conclude;
  end
endmodule
